// ### rtl/nvpc_ctrl.sv
// nonvolatile-memory program/read controller for a display driver
// assumes a plain strobe register port and an array macro on the same clock
// whose read data is valid while its read strobe is high
//
// Functional notes
// R1: command code B7h selects this six-byte settings group.
// R2: unlock code 5Ah enables memory functions; 00h disables them.
// R3: mask bit 1 leaves a bit unprogrammed; 0 programs it.
// R4: one bit enables the programming supply ripple boost.
// R5: supply select codes 0..6 internal levels; code 7 external supply.
// R6: nine-bit index over two bytes picks target register or byte.
// R7: load inhibit bit 1 stops loading stored values into settings.
// R8: supply enable bit switches the programming supply on or off.
// R9: block select set by device in auto mode, by host manually.
// R10: write strobe bit 1 programs indexed target; 0 does nothing.
// R11: read strobe bit 1 reads indexed target; 0 does nothing.
// R12: auto-program bit 1 starts auto programming; 0 stops it.
// R13: sixth byte returns read data once a read was requested.
// R14: two-bit robustness test field is for wafer probe only.
// R15: three-bit read-only count of common voltage programming, 0..4.
// R16: forward code applies at scan direction 0, backward at 1.
// R17: write, read, auto bits ignored unless unlock code enables.
// R18: host settles supply before write or auto, disables after.
//
// register map, by index on i_addr
//   0 unlock code
//   1 programming mask
//   2 supply fields, index bit 8
//   3 index bits 7..0
//   4 operation control
//   5 read-back data, read only
//   6 forward common voltage code
//   7 backward common voltage code
//   8 status: busy, program count
//   9 panel scan direction
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module nvpc_ctrl
    import nvpc_pkg::*;
#(
    parameter int INDEX_W     = 9,
    parameter int PROG_CYCLES = NVPC_PROG_CYCLES,
    parameter logic [8:0] VCOM_INDEX = 9'h000
)(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // array macro
    output logic      [8:0] o_nvm_index,
    output logic      [7:0] o_nvm_wdata,
    output logic      [7:0] o_nvm_mask,
    output logic            o_nvm_prog,
    output logic            o_nvm_read,
    input  wire logic [7:0] i_nvm_rdata,
    // analog controls
    output logic            o_supply_on,
    output logic            o_supply_boost,
    output logic      [2:0] o_supply_sel,
    output logic            o_supply_external,
    output logic            o_load_inhibit,
    output logic            o_block_sel,
    output logic      [1:0] o_test_mode,
    output logic      [7:0] o_vcom_code,
    output logic            o_busy
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (INDEX_W != 9) begin : g_bad_width
        $error("nvpc_ctrl: index width must be 9");
    end
    // the program timer is sixteen bits wide
    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_bad_cycles
        $error("nvpc_ctrl: program cycles out of range");
    end

    // decode of a register index on a given strobe
    function automatic logic hit(input logic stb, input logic [3:0] a,
                                 input logic [3:0] idx);
        hit = stb && (a == idx);
    endfunction : hit

    // parameter bytes and panel settings
    logic [7:0]   unlock_r;
    logic [7:0]   mask_r;
    logic [7:0]   supply_r;
    logic [7:0]   index_lo_r;
    logic [7:0]   control_r;
    logic [7:0]   readback_r;
    logic [7:0]   vcom_fwd_r;
    logic [7:0]   vcom_bwd_r;
    logic         panel_dir_r;

    // sequencer, counters and read-back flag
    logic [2:0]   count_r;
    logic [15:0]  timer_r;
    logic [8:0]   auto_idx_r;
    logic         read_seen_r;
    nvpc_state_t  state_r;

    // views of the parameter bytes
    logic         unlocked;
    logic [8:0]   index;

    // ------------------------------------------------------------
    // unlock and field views
    // ------------------------------------------------------------
    assign unlocked = (unlock_r == NVPC_KEY_ENABLE);          // [R2] [R17]
    assign index    = {supply_r[NVPC_SUP_IDX8_BIT], index_lo_r}; // [R6]

    // host-writable parameter bytes of the B7h group
    // supply bits 3:1 do not exist and read as zero
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            unlock_r   <= NVPC_RST_UNLOCK;
            mask_r     <= NVPC_RST_MASK;
            supply_r   <= NVPC_RST_SUPPLY;
            index_lo_r <= NVPC_RST_INDEX_LO;
        end
        else
        begin
            if (hit(i_wr, i_addr, NVPC_IDX_UNLOCK))   unlock_r   <= i_wdata; // [R1]
            if (hit(i_wr, i_addr, NVPC_IDX_MASK))     mask_r     <= i_wdata;
            if (hit(i_wr, i_addr, NVPC_IDX_SUPPLY))   supply_r   <= i_wdata & 8'hF1;
            if (hit(i_wr, i_addr, NVPC_IDX_INDEX_LO)) index_lo_r <= i_wdata;
        end
    end

    // forward and backward common voltage codes
    // both are held; the scan direction picks one at the output
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            vcom_fwd_r  <= NVPC_RST_VCOM;
            vcom_bwd_r  <= NVPC_RST_VCOM;
        end
        else
        begin
            if (hit(i_wr, i_addr, NVPC_IDX_VCOM_FWD)) vcom_fwd_r  <= i_wdata;
            if (hit(i_wr, i_addr, NVPC_IDX_VCOM_BWD)) vcom_bwd_r  <= i_wdata;
        end
    end

    // panel scan direction, bit 0 of its byte
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            panel_dir_r <= 1'b0;
        else if (hit(i_wr, i_addr, NVPC_IDX_PANEL))
            panel_dir_r <= i_wdata[0];
    end

    // ------------------------------------------------------------
    // control byte: host writes, hardware clears finished strobes
    // ------------------------------------------------------------
    // a host write beats a same-cycle hardware clear, so a new
    // operation can be queued as soon as the last one ends
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            control_r <= NVPC_RST_CONTROL;
        end
        else if (hit(i_wr, i_addr, NVPC_IDX_CONTROL))
        begin
            control_r <= i_wdata;                              // host write wins
            // strobes are dropped while the key is wrong
            if (!unlocked)
            begin
                control_r[NVPC_CTL_WRITE] <= 1'b0;             // [R17]
                control_r[NVPC_CTL_READ]  <= 1'b0;             // [R17]
                control_r[NVPC_CTL_AUTO]  <= 1'b0;             // [R17]
            end
        end
        else
        begin
            if (state_r == NVPC_READ)
                control_r[NVPC_CTL_READ] <= 1'b0;              // [R11]
            if (state_r == NVPC_PROG && timer_r == 16'h0001)
                control_r[NVPC_CTL_WRITE] <= 1'b0;             // [R10]
            if (state_r == NVPC_AUTO && timer_r == 16'h0001 && auto_idx_r == index)
                control_r[NVPC_CTL_AUTO] <= 1'b0;              // [R12]
            if (state_r == NVPC_AUTO)
                control_r[NVPC_CTL_BLOCK_SEL] <= 1'b1;         // [R9]
        end
    end

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    // auto mode programs index 0 up to the set index, one full
    // pulse each; clearing the auto bit abandons the walk
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r    <= NVPC_IDLE;
            timer_r    <= 16'h0000;
            auto_idx_r <= 9'h000;
        end
        else
        begin
            case (state_r)
                NVPC_IDLE:
                begin
                    // a read is served first when several bits are set
                    if (unlocked && control_r[NVPC_CTL_READ])
                        state_r <= NVPC_READ;                  // [R11]
                    else if (unlocked && control_r[NVPC_CTL_WRITE])
                    begin
                        state_r <= NVPC_PROG;                  // [R10]
                        timer_r <= 16'(PROG_CYCLES);
                    end
                    else if (unlocked && control_r[NVPC_CTL_AUTO])
                    begin
                        state_r    <= NVPC_AUTO;               // [R12]
                        timer_r    <= 16'(PROG_CYCLES);
                        auto_idx_r <= 9'h000;
                    end
                end
                NVPC_READ:
                    state_r <= NVPC_IDLE;
                NVPC_PROG:
                begin
                    timer_r <= timer_r - 16'h0001;
                    if (timer_r == 16'h0001)
                        state_r <= NVPC_IDLE;
                end
                NVPC_AUTO:
                begin
                    if (!control_r[NVPC_CTL_AUTO] || !unlocked)
                        state_r <= NVPC_IDLE;                  // [R12] stop
                    else if (timer_r == 16'h0001)
                    begin
                        if (auto_idx_r == index)
                            state_r <= NVPC_IDLE;
                        auto_idx_r <= auto_idx_r + 9'h001;
                        timer_r    <= 16'(PROG_CYCLES);
                    end
                    else
                        timer_r <= timer_r - 16'h0001;
                end
                default:
                    state_r <= NVPC_IDLE;
            endcase
        end
    end

    // read-back capture while the array read strobe is out; the
    // macro output is not valid data outside that cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            readback_r  <= NVPC_RST_READBACK;
            read_seen_r <= 1'b0;
        end
        else if (o_nvm_read)
        begin
            readback_r  <= i_nvm_rdata;                        // [R13]
            read_seen_r <= 1'b1;
        end
    end

    // count of finished common voltage programmings, saturates at 4
    // only a manual pulse at the common voltage index counts
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            count_r <= 3'h0;
        else if (state_r == NVPC_PROG && timer_r == 16'h0001 &&
                 index == VCOM_INDEX && count_r != NVPC_COUNT_MAX)
            count_r <= count_r + 3'h1;                         // [R15]
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // array macro index, data, mask and strobes
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_nvm_index       <= 9'h000;
            o_nvm_wdata       <= 8'h00;
            o_nvm_mask        <= 8'h00;
            o_nvm_prog        <= 1'b0;
            o_nvm_read        <= 1'b0;
        end
        else
        begin
            o_nvm_index       <= (state_r == NVPC_AUTO) ? auto_idx_r : index; // [R6]
            o_nvm_wdata       <= (state_r == NVPC_AUTO) ? vcom_fwd_r : readback_r;
            o_nvm_mask        <= mask_r;                                // [R3]
            o_nvm_prog        <= (state_r == NVPC_PROG) || (state_r == NVPC_AUTO); // [R10]
            o_nvm_read        <= (state_r == NVPC_READ);                // [R11]
        end
    end

    // supply and analog levels follow their fields one cycle late
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_supply_on       <= 1'b0;
            o_supply_boost    <= 1'b0;
            o_supply_sel      <= NVPC_RST_SUPPLY[NVPC_SUP_SEL_LSB +: 3];
            o_supply_external <= 1'b0;
            o_load_inhibit    <= 1'b0;
            o_block_sel       <= 1'b0;
            o_test_mode       <= 2'h0;
        end
        else
        begin
            o_supply_on       <= control_r[NVPC_CTL_SUPPLY_EN];         // [R8] [R18]
            o_supply_boost    <= supply_r[NVPC_SUP_BOOST_BIT];          // [R4]
            o_supply_sel      <= supply_r[NVPC_SUP_SEL_LSB +: 3];       // [R5]
            o_supply_external <= (supply_r[NVPC_SUP_SEL_LSB +: 3] == NVPC_SUP_EXTERNAL); // [R5]
            o_load_inhibit    <= control_r[NVPC_CTL_INHIBIT];           // [R7]
            o_block_sel       <= control_r[NVPC_CTL_BLOCK_SEL];         // [R9]
            o_test_mode       <= control_r[NVPC_CTL_TEST_LSB +: 2];     // [R14]
        end
    end

    // common voltage code and busy flag
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_vcom_code       <= NVPC_RST_VCOM;
            o_busy            <= 1'b0;
        end
        else
        begin
            o_vcom_code       <= panel_dir_r ? vcom_bwd_r : vcom_fwd_r; // [R16]
            o_busy            <= (state_r != NVPC_IDLE);
        end
    end

    // read data, one cycle after the strobe
    // unmapped indices and idle cycles return zero
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                NVPC_IDX_UNLOCK:   o_rdata <= unlock_r;
                NVPC_IDX_MASK:     o_rdata <= mask_r;
                NVPC_IDX_SUPPLY:   o_rdata <= supply_r;
                NVPC_IDX_INDEX_LO: o_rdata <= index_lo_r;
                NVPC_IDX_CONTROL:  o_rdata <= control_r;
                NVPC_IDX_READBACK: o_rdata <= read_seen_r ? readback_r : 8'h00; // [R13]
                NVPC_IDX_VCOM_FWD: o_rdata <= vcom_fwd_r;
                NVPC_IDX_VCOM_BWD: o_rdata <= vcom_bwd_r;
                NVPC_IDX_STATUS:   o_rdata <= {4'h0, (state_r != NVPC_IDLE), count_r}; // [R15]
                NVPC_IDX_PANEL:    o_rdata <= {7'h00, panel_dir_r};
                default:           o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

endmodule : nvpc_ctrl

`default_nettype wire

// ### rtl/nvpc_pkg.sv
// package for the nonvolatile-memory settings group controller
// assumes one 20 MHz clock and a plain strobe register port
package nvpc_pkg;

    // ------------------------------------------------------------
    // command and keys
    // ------------------------------------------------------------
    localparam logic [7:0] NVPC_CMD_SETTINGS = 8'hB7;
    localparam logic [7:0] NVPC_KEY_ENABLE   = 8'h5A;
    localparam logic [7:0] NVPC_KEY_DISABLE  = 8'h00;

    // ------------------------------------------------------------
    // register indices (parameter byte order)
    // ------------------------------------------------------------
    localparam logic [3:0] NVPC_IDX_UNLOCK   = 4'h0;
    localparam logic [3:0] NVPC_IDX_MASK     = 4'h1;
    localparam logic [3:0] NVPC_IDX_SUPPLY   = 4'h2;
    localparam logic [3:0] NVPC_IDX_INDEX_LO = 4'h3;
    localparam logic [3:0] NVPC_IDX_CONTROL  = 4'h4;
    localparam logic [3:0] NVPC_IDX_READBACK = 4'h5;
    localparam logic [3:0] NVPC_IDX_VCOM_FWD = 4'h6;
    localparam logic [3:0] NVPC_IDX_VCOM_BWD = 4'h7;
    localparam logic [3:0] NVPC_IDX_STATUS   = 4'h8;
    localparam logic [3:0] NVPC_IDX_PANEL    = 4'h9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] NVPC_RST_UNLOCK   = 8'hFF;
    localparam logic [7:0] NVPC_RST_MASK     = 8'h00;
    localparam logic [7:0] NVPC_RST_SUPPLY   = 8'h30;
    localparam logic [7:0] NVPC_RST_INDEX_LO = 8'h00;
    localparam logic [7:0] NVPC_RST_CONTROL  = 8'h00;
    localparam logic [7:0] NVPC_RST_READBACK = 8'h00;
    localparam logic [7:0] NVPC_RST_VCOM     = 8'h4D;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NVPC_SUP_BOOST_BIT = 7;
    localparam int NVPC_SUP_SEL_LSB   = 4;
    localparam int NVPC_SUP_IDX8_BIT  = 0;
    localparam int NVPC_CTL_INHIBIT   = 7;
    localparam int NVPC_CTL_SUPPLY_EN = 6;
    localparam int NVPC_CTL_BLOCK_SEL = 5;
    localparam int NVPC_CTL_WRITE     = 4;
    localparam int NVPC_CTL_TEST_LSB  = 2;
    localparam int NVPC_CTL_READ      = 1;
    localparam int NVPC_CTL_AUTO      = 0;
    localparam logic [2:0] NVPC_SUP_EXTERNAL = 3'h7;
    localparam logic [2:0] NVPC_COUNT_MAX    = 3'h4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int NVPC_CLK_MHZ       = 20;
    localparam int NVPC_PROG_PULSE_NS = 10000;
    localparam int NVPC_PROG_CYCLES   =
        (NVPC_PROG_PULSE_NS * NVPC_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        NVPC_IDLE,
        NVPC_READ,
        NVPC_PROG,
        NVPC_AUTO
    } nvpc_state_t;

endpackage : nvpc_pkg

// ### dv/nvpc_ctrl_asserts.sv
// port checker for the nonvolatile settings controller
// assumes it is bound onto nvpc_ctrl; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module nvpc_ctrl_chk
    import nvpc_pkg::*;
#(
    parameter int PROG_CYCLES = NVPC_PROG_CYCLES
)(
    // clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // controller outputs
    input wire logic       o_nvm_prog,
    input wire logic       o_nvm_read,
    input wire logic       o_supply_on,
    input wire logic       o_supply_boost,
    input wire logic [2:0] o_supply_sel,
    input wire logic       o_supply_external,
    input wire logic       o_load_inhibit,
    input wire logic [1:0] o_test_mode,
    input wire logic [7:0] o_vcom_code
);
    logic [7:0]  key_r, fwd_r, bwd_r;
    logic        pnl_r, auto_r;
    logic [15:0] run_r;
    // shadow of host writes
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            key_r  <= NVPC_RST_UNLOCK;
            fwd_r  <= NVPC_RST_VCOM;
            bwd_r  <= NVPC_RST_VCOM;
            pnl_r  <= 1'b0;
            auto_r <= 1'b0;
        end
        else if (i_wr)
        begin
            case (i_addr)
                NVPC_IDX_UNLOCK:   key_r  <= i_wdata;
                NVPC_IDX_VCOM_FWD: fwd_r  <= i_wdata;
                NVPC_IDX_VCOM_BWD: bwd_r  <= i_wdata;
                NVPC_IDX_PANEL:    pnl_r  <= i_wdata[0];
                NVPC_IDX_CONTROL:  auto_r <= i_wdata[NVPC_CTL_AUTO];
                default:           ;
            endcase
        end
    end
    // length of the current programming run
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !o_nvm_prog)
            run_r <= 16'h0000;
        else
            run_r <= run_r + 16'h0001;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_ctl_wr;
        i_wr && i_addr == NVPC_IDX_CONTROL;
    endsequence
    sequence s_sup_wr;
        i_wr && i_addr == NVPC_IDX_SUPPLY;
    endsequence
    AST_RD_PULSE: assert property (o_nvm_read |=> !o_nvm_read)
        else $error("array read longer than one cycle");
    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_SUP_EXT: assert property (o_supply_external == (o_supply_sel == 3'h7))
        else $error("external supply flag wrong");
    AST_SUP_WR: assert property (s_sup_wr |-> ##2 o_supply_boost == $past(i_wdata[7], 2)
        && o_supply_sel == $past(i_wdata[6:4], 2))
        else $error("supply fields not applied");
    AST_CTL_WR: assert property (s_ctl_wr |-> ##2 o_load_inhibit == $past(i_wdata[7], 2)
        && o_supply_on == $past(i_wdata[6], 2) && o_test_mode == $past(i_wdata[3:2], 2))
        else $error("control fields not applied");
    AST_READ_KEY: assert property (o_nvm_read |-> $past(key_r, 2) == NVPC_KEY_ENABLE)
        else $error("array read while locked");
    AST_PROG_KEY: assert property ($rose(o_nvm_prog) |-> $past(key_r, 2) == NVPC_KEY_ENABLE)
        else $error("programming while locked");
    AST_PROG_LEN: assert property ($fell(o_nvm_prog) && !auto_r |-> run_r == 16'(PROG_CYCLES))
        else $error("manual program pulse length wrong");
    AST_VCOM_SEL: assert property (!i_wr [*2] |-> o_vcom_code == (pnl_r ? bwd_r : fwd_r))
        else $error("common voltage code not per scan direction");
endmodule : nvpc_ctrl_chk
bind nvpc_ctrl nvpc_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_nvm_prog, .o_nvm_read,
    .o_supply_on, .o_supply_boost, .o_supply_sel, .o_supply_external, .o_load_inhibit,
    .o_test_mode, .o_vcom_code);
`default_nettype wire

// ### dv/nvpc_nvm_model.sv
// behavioural array macro for the settings controller
// assumes index, strobes and data registered on the same clock
`timescale 1ns/100ps
`default_nettype none
module nvpc_nvm_model
(
    // controller side
    input  wire logic       i_clk,
    input  wire logic [8:0] i_index,
    input  wire logic       i_read,
    input  wire logic       i_prog,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_mask,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem_r [512];
    // known contents per byte, repeating every 256 entries
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem_r[i] = 8'(i) ^ 8'h5A;
    end
    // program only unmasked bits of the indexed byte
    always @(posedge i_clk)
    begin
        if (i_prog)
            mem_r[i_index] <= (mem_r[i_index] & i_mask) | (i_wdata & ~i_mask);
    end
    // data only during the read strobe, inverted otherwise
    assign o_rdata = i_read ? mem_r[i_index] : ~mem_r[i_index];
endmodule : nvpc_nvm_model
`default_nettype wire

// ### dv/nvpc_tb.sv
// self-checking bench for the nonvolatile settings controller
// assumes the array model and the bound port checker alongside
`timescale 1ns/100ps
`default_nettype none
module testbench
    import nvpc_pkg::*;
;
    localparam int PC = 3;
    logic       i_clk, i_srst, i_wr, i_rd;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_nvm_wdata, o_nvm_mask, i_nvm_rdata, o_vcom_code, d;
    logic [8:0] o_nvm_index;
    logic       o_nvm_prog, o_nvm_read, o_supply_on, o_supply_boost, o_supply_external;
    logic       o_load_inhibit, o_block_sel, o_busy;
    logic [2:0] o_supply_sel;
    logic [1:0] o_test_mode;
    int         err_count = 0;
    int         compares = 0;
    logic [7:0] rst_v [10] = '{8'hFF, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h4D, 8'h4D, 8'h00, 8'h00};
    logic [7:0] fld [5] = '{8'hFC, 8'h6C, 8'hA4, 8'h18, 8'h00};
    // device under test and array model
    nvpc_ctrl #(.PROG_CYCLES(PC), .VCOM_INDEX(9'h0AA)) dut (
        .i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_nvm_index,
        .o_nvm_wdata, .o_nvm_mask, .o_nvm_prog, .o_nvm_read, .i_nvm_rdata, .o_supply_on,
        .o_supply_boost, .o_supply_sel, .o_supply_external, .o_load_inhibit, .o_block_sel,
        .o_test_mode, .o_vcom_code, .o_busy);
    nvpc_nvm_model mdl (
        .i_clk, .i_index(o_nvm_index), .i_read(o_nvm_read), .i_prog(o_nvm_prog),
        .i_wdata(o_nvm_wdata), .i_mask(o_nvm_mask), .o_rdata(i_nvm_rdata));
    // 20 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr
    // byte comparison
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk8
    // one-cycle register read, data taken the cycle after
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        @(negedge i_clk);
        chk8(o_rdata, e, m);
    endtask : rdc
    // bounded wait for the controller to go idle
    task automatic idle();
        int n;
        n = 0;
        repeat (3) @(negedge i_clk);
        while (o_busy !== 1'b0 && n < 500)
        begin
            @(negedge i_clk);
            n++;
        end
        chk8({7'h00, o_busy}, 8'h00, "busy stuck");
    endtask : idle
    // set index, raise supply, then issue operation bits
    task automatic op(input logic [8:0] ix, input logic [7:0] c);
        wr(NVPC_IDX_SUPPLY, {7'h00, ix[8]});
        wr(NVPC_IDX_INDEX_LO, ix[7:0]);
        wr(NVPC_IDX_CONTROL, 8'h40);
        repeat (4) @(posedge i_clk);
        wr(NVPC_IDX_CONTROL, c | 8'h40);
        idle();
    endtask : op
    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, err_count);
    endtask : done
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    // watchdog
    initial
    begin
        #(20000 * 50);
        err_count++;
        give_verdict();
    end
    // test sequence
    initial
    begin
        i_srst  = 1'b1;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        i_addr  = 4'h0;
        i_wdata = 8'h00;
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 10; i++)
            rdc(4'(i), rst_v[i], "reset value");
        wr(4'hF, 8'hA5);
        wr(NVPC_IDX_READBACK, 8'hA5);
        rdc(4'hF, 8'h00, "unmapped");
        rdc(NVPC_IDX_READBACK, 8'h00, "read-only");
        done("reset");
        wr(NVPC_IDX_CONTROL, 8'h13);
        rdc(NVPC_IDX_CONTROL, 8'h00, "locked control");
        wr(NVPC_IDX_UNLOCK, NVPC_KEY_DISABLE);
        wr(NVPC_IDX_CONTROL, 8'h13);
        rdc(NVPC_IDX_CONTROL, 8'h00, "disabled control");
        wr(NVPC_IDX_UNLOCK, NVPC_KEY_ENABLE);
        foreach (fld[k])
        begin
            d = fld[k];
            wr(NVPC_IDX_SUPPLY, d);
            wr(NVPC_IDX_CONTROL, d & 8'hEC);
            repeat (2) @(negedge i_clk);
            chk8({3'h0, o_supply_boost, o_supply_sel, o_supply_external},
                 {3'h0, d[7], d[6:4], d[6:4] == 3'h7}, "supply fields");
            chk8({3'h0, o_load_inhibit, o_supply_on, o_block_sel, o_test_mode},
                 {3'h0, d[7:5], d[3:2]}, "control fields");
        end
        done("fields");
        op(9'h123, 8'h02);
        rdc(NVPC_IDX_CONTROL, 8'h40, "read bit clears");
        rdc(NVPC_IDX_READBACK, 8'h23 ^ 8'h5A, "read data");
        wr(NVPC_IDX_MASK, 8'h0F);
        op(9'h1FF, 8'h10);
        wr(NVPC_IDX_CONTROL, 8'h00);
        op(9'h1FF, 8'h02);
        rdc(NVPC_IDX_READBACK, ((8'hFF ^ 8'h5A) & 8'h0F) | ((8'h23 ^ 8'h5A) & 8'hF0),
            "masked program");
        done("read and program");
        for (int n = 1; n <= 5; n++)
        begin
            op(9'h0AA, 8'h10);
            wr(NVPC_IDX_CONTROL, 8'h00);
            rdc(NVPC_IDX_STATUS, (n > 4) ? 8'h04 : 8'(n), "program count");
        end
        done("count");
        wr(NVPC_IDX_VCOM_FWD, 8'h11);
        wr(NVPC_IDX_VCOM_BWD, 8'h22);
        for (int p = 0; p < 3; p++)
        begin
            wr(NVPC_IDX_PANEL, 8'(p & 1));
            repeat (2) @(negedge i_clk);
            chk8(o_vcom_code, p[0] ? 8'h22 : 8'h11, "direction code");
        end
        done("direction");
        wr(NVPC_IDX_MASK, 8'h00);
        op(9'h002, 8'h01);
        rdc(NVPC_IDX_CONTROL, 8'h60, "auto run ends");
        wr(NVPC_IDX_CONTROL, 8'h00);
        op(9'h001, 8'h02);
        rdc(NVPC_IDX_READBACK, 8'h11, "auto programmed");
        done("auto");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
